//--- verilog/sds_pkg.sv
// shared constants and carriers of the system descriptor checker
// assumes one core clock; requests come from core sequencing logic
package sds_pkg;
    // descriptor type codes
    localparam logic [3:0] SDS_TY_TSS16_AV = 4'h1;
    localparam logic [3:0] SDS_TY_LDT = 4'h2;
    localparam logic [3:0] SDS_TY_TSS16_BSY = 4'h3;
    localparam logic [3:0] SDS_TY_CALL16 = 4'h4;
    localparam logic [3:0] SDS_TY_TASK = 4'h5;
    localparam logic [3:0] SDS_TY_INTR16 = 4'h6;
    localparam logic [3:0] SDS_TY_TRAP16 = 4'h7;
    localparam logic [3:0] SDS_TY_TSS32_AV = 4'h9;
    localparam logic [3:0] SDS_TY_TSS32_BSY = 4'hB;
    localparam logic [3:0] SDS_TY_CALL32 = 4'hC;
    localparam logic [3:0] SDS_TY_INTR32 = 4'hE;
    localparam logic [3:0] SDS_TY_TRAP32 = 4'hF;
    // field positions in the high descriptor word (access byte at 15..8)
    localparam int SDS_HI_TYPE_LSB = 8;
    localparam int SDS_HI_S_BIT = 12;
    localparam int SDS_HI_DPL_LSB = 13;
    localparam int SDS_HI_P_BIT = 15;
    localparam int SDS_HI_LIM_LSB = 16;
    localparam int SDS_HI_G_BIT = 23;
    localparam int SDS_HI_B3_LSB = 24;
    localparam int SDS_HI_WC_LSB = 0;
    // access byte bits of a destination descriptor
    localparam int SDS_ACC_S_BIT = 4;
    localparam int SDS_ACC_EXEC_BIT = 3;
    // fault vectors
    localparam logic [7:0] SDS_VEC_NP = 8'h0B;
    localparam logic [7:0] SDS_VEC_GP = 8'h0D;
    localparam logic [7:0] SDS_VEC_NONE = 8'h00;
    // register offsets and reset values
    localparam logic [3:0] SDS_REG_TASK_SEL = 4'h0;
    localparam logic [3:0] SDS_REG_STATUS = 4'h4;
    localparam logic [15:0] SDS_TASK_SEL_RST = 16'h0000;

    typedef enum logic [2:0] {
        SDS_CL_BAD = 3'h0,
        SDS_CL_LDT = 3'h1,
        SDS_CL_TSS = 3'h2,
        SDS_CL_CALL = 3'h3,
        SDS_CL_TASK = 3'h4,
        SDS_CL_INTR = 3'h5,
        SDS_CL_TRAP = 3'h6
    } sds_class_t;

    typedef struct packed {
        logic [31:0] base;
        logic [19:0] limit;
        logic gran;
        logic present;
        logic [1:0] descriptor_privilege_level;
        logic seg_class;
        logic [3:0] dtype;
    } sds_fields_t;

    typedef struct packed {
        logic [31:0] lo;
        logic [31:0] hi;
        logic in_local;
        logic [1:0] cpl;
        logic priv_change;
        logic [7:0] dest_access;
        logic if_in;
    } sds_req_t;

    typedef struct packed {
        sds_class_t cls;
        logic wide;
        logic busy;
        logic gp;
        logic np;
        logic [7:0] vector;
        logic [15:0] sel;
        logic [31:0] offset;
        logic [4:0] copy_count;
        logic if_out;
    } sds_rsp_t;
endpackage

//--- verilog/sds_checker.sv
// system descriptor checker: decodes one 64-bit system descriptor per
// request, checks it and answers one cycle later with fields and faults.
// assumes requests come from core logic on mclk, so no synchronisers.
//
// How it works
// R01: type 2 is a local table descriptor
// R02: local table descriptor privilege level is ignored
// R03: local table descriptor only from global table
// R04: tss types 1,9 available; 3,B busy
// R05: tss types 1,3 16-bit, 9,B 32-bit
// R06: gate types 4,5,6,7,C,E,F decoded
// R07: word count only for privilege-changing calls
// R08: copy word count parameters on privilege change
// R09: handler entry is selector plus offset
// R10: interrupt gate clears if, trap keeps it
// R11: task gate uses selector only, needs tss
// R12: wrong destination kind raises vector 13
// R13: present clear raises vector 11
// R14: class bit 4 must be zero
// R15: same access byte layout for all gates
// R16: privilege level compared against current level
// R17: task selector register holds current tss
// R18: extract 32-bit base and 20-bit limit
// R19: types 0,8,A,D fault as reserved
// R20: assemble base and limit from both words
`timescale 1ns/1ps
`default_nettype none
module sds_checker
    import sds_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    // one descriptor per request strobe
    input wire logic req_valid,
    input wire sds_req_t req,
    // registered answer, held until the next one
    output logic rsp_valid,
    output sds_rsp_t rsp,
    output sds_fields_t fields,
    // software register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic [15:0] task_sel
);

    // true for any of the four task state segment codes; used on the
    // destination access byte, where a busy segment is still a legal
    // target for the kind check (busy-ness is the task switcher's job)
    function automatic logic is_tss(input logic [3:0] t);
        is_tss = (t == SDS_TY_TSS16_AV) || (t == SDS_TY_TSS16_BSY) ||
                 (t == SDS_TY_TSS32_AV) || (t == SDS_TY_TSS32_BSY);
    endfunction

    // class of a system type code; unknown codes map to bad. the class
    // bit is not looked at here, so a code or data descriptor still gets
    // a class; the fault chain below throws it out first
    function automatic sds_class_t type_class(input logic [3:0] t);
        case (t)
            SDS_TY_LDT: type_class = SDS_CL_LDT;
            SDS_TY_TSS16_AV, SDS_TY_TSS16_BSY,
            SDS_TY_TSS32_AV, SDS_TY_TSS32_BSY: type_class = SDS_CL_TSS;
            SDS_TY_CALL16, SDS_TY_CALL32: type_class = SDS_CL_CALL;
            SDS_TY_TASK: type_class = SDS_CL_TASK;
            SDS_TY_INTR16, SDS_TY_INTR32: type_class = SDS_CL_INTR;
            SDS_TY_TRAP16, SDS_TY_TRAP32: type_class = SDS_CL_TRAP;
            default: type_class = SDS_CL_BAD;
        endcase
    endfunction

    sds_fields_t fields_nxt; // decoded descriptor fields
    sds_rsp_t rsp_nxt; // answer for this request
    sds_rsp_t rsp_r; // registered answer
    sds_fields_t fields_r; // registered fields
    logic rsp_valid_r; // answer strobe
    logic [15:0] task_sel_r; // current task selector
    logic [31:0] rdata_r; // read data, valid one cycle after strobe
    sds_class_t cls; // class of request type
    logic dest_code; // destination is a code segment
    logic dest_tss; // destination is a task state segment
    logic priv_fail; // current level too weak for descriptor

    // field extraction, same layout for every system descriptor; the
    // 16-bit style (upper word zero) falls out naturally since base and
    // limit bits above that style's width simply read as zero
    // (gate descriptors run through here too; their fields are unused)
    always_comb begin
        fields_nxt.base = {req.hi[SDS_HI_B3_LSB +: 8], req.hi[7:0],
                           req.lo[31:16]}; // see R18 see R20
        fields_nxt.limit = {req.hi[SDS_HI_LIM_LSB +: 4], req.lo[15:0]}; // see R20
        fields_nxt.gran = req.hi[SDS_HI_G_BIT];
        fields_nxt.present = req.hi[SDS_HI_P_BIT]; // see R15
        fields_nxt.descriptor_privilege_level = req.hi[SDS_HI_DPL_LSB +: 2];
        fields_nxt.seg_class = req.hi[SDS_HI_S_BIT];
        fields_nxt.dtype = req.hi[SDS_HI_TYPE_LSB +: 4];
    end

    // classification and destination kind tests; the destination access
    // byte is fetched by the core, so a stale byte gives a wrong verdict
    // and the core must present it in the same cycle as the gate
    always_comb begin
        cls = type_class(fields_nxt.dtype); // see R01 see R06 see R19
        dest_code = req.dest_access[SDS_ACC_S_BIT] && req.dest_access[SDS_ACC_EXEC_BIT];
        dest_tss = !req.dest_access[SDS_ACC_S_BIT] && is_tss(req.dest_access[3:0]);
        // numerically larger level is less privileged
        priv_fail = (cls != SDS_CL_LDT) && (req.cpl > fields_nxt.descriptor_privilege_level); // see R16 see R02
    end

    // answer formation; faults checked in a fixed order so that a
    // class error always wins over not-present, which the core relies on.
    // only the first fault is reported: one vector per answer keeps the
    // vector field of the status word a single byte wide, at the cost of hiding a second
    // fault until the first is fixed
    always_comb begin
        rsp_nxt.cls = cls;
        rsp_nxt.wide = fields_nxt.dtype[3]; // see R05
        rsp_nxt.busy = (cls == SDS_CL_TSS) && fields_nxt.dtype[1]; // see R04
        rsp_nxt.sel = req.lo[31:16];
        rsp_nxt.offset = fields_nxt.dtype[3] ? {req.hi[31:16], req.lo[15:0]} :
                         {16'h0000, req.lo[15:0]}; // see R09
        rsp_nxt.copy_count = 5'h00;
        rsp_nxt.if_out = req.if_in;
        rsp_nxt.gp = 1'b0;
        rsp_nxt.np = 1'b0;
        if (cls == SDS_CL_CALL && req.priv_change) begin
            rsp_nxt.copy_count = req.hi[SDS_HI_WC_LSB +: 5]; // see R07 see R08
        end
        if (cls == SDS_CL_INTR) begin
            rsp_nxt.if_out = 1'b0; // see R10
        end
        if (cls == SDS_CL_TASK) begin
            rsp_nxt.offset = 32'h0000_0000; // see R11
        end
        if (cls == SDS_CL_LDT || cls == SDS_CL_TSS || cls == SDS_CL_BAD) begin
            // tables and task segments carry no entry pointer
            rsp_nxt.sel = 16'h0000;
            rsp_nxt.offset = 32'h0000_0000;
        end
        if (fields_nxt.seg_class) begin
            rsp_nxt.gp = 1'b1; // see R14
        end else if (cls == SDS_CL_BAD) begin
            rsp_nxt.gp = 1'b1; // see R19
        end else if (cls == SDS_CL_LDT && req.in_local) begin
            rsp_nxt.gp = 1'b1; // see R03
        end else if (priv_fail) begin
            rsp_nxt.gp = 1'b1; // see R16
        end else if (!fields_nxt.present) begin
            rsp_nxt.np = 1'b1; // see R13
        end else if (cls == SDS_CL_TASK && !dest_tss) begin
            rsp_nxt.gp = 1'b1; // see R11 see R12
        end else if ((cls == SDS_CL_CALL || cls == SDS_CL_INTR ||
                      cls == SDS_CL_TRAP) && !dest_code) begin
            rsp_nxt.gp = 1'b1; // see R12
        end
        rsp_nxt.vector = rsp_nxt.gp ? SDS_VEC_GP :
                         (rsp_nxt.np ? SDS_VEC_NP : SDS_VEC_NONE);
    end

    // answer registers; a request is answered on the next edge. the
    // answer is held between requests so the core may read it late;
    // only rsp_valid marks a fresh one
    always_ff @(posedge mclk) begin
        if (reset) begin
            rsp_valid_r <= 1'b0;
            rsp_r <= '0;
            fields_r <= '0;
        end else begin
            rsp_valid_r <= req_valid;
            if (req_valid) begin
                rsp_r <= rsp_nxt;
                fields_r <= fields_nxt;
            end
        end
    end

    // task selector register, written by software; no check on the
    // value, since loading it is a privileged act outside this block
    always_ff @(posedge mclk) begin
        if (reset) begin
            task_sel_r <= SDS_TASK_SEL_RST;
        end else if (reg_wr && reg_addr == SDS_REG_TASK_SEL) begin
            task_sel_r <= reg_wdata[15:0]; // see R17
        end
    end

    // read port; unmapped addresses read as zero. the status word is a
    // snapshot of the last answer, so a read racing a request sees the
    // older answer
    always_ff @(posedge mclk) begin
        if (reset) begin
            rdata_r <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                SDS_REG_TASK_SEL: rdata_r <= {16'h0000, task_sel_r};
                SDS_REG_STATUS: rdata_r <= {16'h0000, rsp_r.vector, 1'b0, rsp_r.cls,
                                            rsp_r.gp, rsp_r.np, rsp_r.busy, rsp_r.wide};
                default: rdata_r <= 32'h0000_0000;
            endcase
        end else begin
            rdata_r <= 32'h0000_0000;
        end
    end

    // outputs come straight from flip-flops, no logic after them
    assign rsp_valid = rsp_valid_r;
    assign rsp = rsp_r;
    assign fields = fields_r;
    assign reg_rdata = rdata_r;
    assign task_sel = task_sel_r;

    // checks on the answer one cycle after the request, and on the task selector one cycle after a write; reset
    // disables them since the answer registers are forced to zero then
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    ldt_class_a: assert property (req_valid && req.hi[11:8] == 4'h2 && !req.hi[12]
        |=> rsp.cls == SDS_CL_LDT) else $error("type 2 not local table"); // see R01
    ldt_place_a: assert property (req_valid && req.hi[11:8] == 4'h2 && !req.hi[12]
        && req.in_local |=> rsp.gp && rsp.vector == 8'h0D)
        else $error("local table descriptor in local table accepted"); // see R03
    ldt_dpl_a: assert property (req_valid && req.hi[11:8] == 4'h2 && req.hi[15]
        && !req.hi[12] && !req.in_local |=> !rsp.gp && !rsp.np)
        else $error("local table descriptor faulted on level"); // see R02
    tss_busy_a: assert property (req_valid && (req.hi[11:8] == 4'h3 || req.hi[11:8] == 4'hB)
        |=> rsp.busy && rsp.cls == SDS_CL_TSS) else $error("busy tss missed"); // see R04
    tss_width_a: assert property (req_valid && req.hi[11:8] == 4'h1
        |=> !rsp.wide && !rsp.busy) else $error("16-bit tss wrong"); // see R05
    count_use_a: assert property (req_valid && !req.priv_change
        |=> rsp.copy_count == 5'h00) else $error("count used without level change"); // see R07
    count_copy_a: assert property (req_valid && req.hi[11:8] == 4'hC && !req.hi[12]
        && req.priv_change |=> rsp.copy_count == $past(req.hi[4:0]))
        else $error("count not passed"); // see R08
    intr_if_a: assert property (req_valid && req.hi[11:8] == 4'hE
        |=> !rsp.if_out) else $error("interrupt gate kept if"); // see R10
    trap_if_a: assert property (req_valid && req.hi[11:8] == 4'h7
        |=> rsp.if_out == $past(req.if_in)) else $error("trap gate changed if"); // see R10
    task_off_a: assert property (req_valid && req.hi[11:8] == 4'h5
        |=> rsp.offset == 32'h0) else $error("task gate offset used"); // see R11
    not_present_a: assert property (rsp_valid && rsp.np |-> rsp.vector == 8'h0B && !rsp.gp)
        else $error("not present vector wrong"); // see R13
    class_bit_a: assert property (req_valid && req.hi[12]
        |=> rsp.gp) else $error("class bit set accepted"); // see R14
    reserved_a: assert property (req_valid && req.hi[10:8] == 3'h0 && !req.hi[12]
        |=> rsp.gp && rsp.cls == SDS_CL_BAD) else $error("reserved type accepted"); // see R19
    base_lim_a: assert property (req_valid |=> fields.base[15:0] == $past(req.lo[31:16])
        && fields.limit[19:16] == $past(req.hi[19:16])) else $error("base or limit wrong"); // see R20
    level_a: assert property (req_valid && req.hi[11:8] == 4'hC && !req.hi[12]
        && req.cpl > req.hi[14:13] |=> rsp.gp) else $error("weak level accepted"); // see R16
    tsel_a: assert property (reg_wr && reg_addr == 4'h0
        |=> task_sel == $past(reg_wdata[15:0])) else $error("task selector not loaded"); // see R17

    // answer timing: one strobe per request, exactly one edge later,
    // and quiet otherwise so the core can count answers blindly
    ans_valid_a: assert property (req_valid |=> rsp_valid)
        else $error("request not answered");
    ans_quiet_a: assert property (!req_valid |=> !rsp_valid)
        else $error("answer without request");
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside read cycle");

    // gate and segment decoding: width follows bit 3 of the type code,
    // the class is decoded from all four bits of the type code
    call_class_a: assert property (req_valid && req.hi[11:8] == 4'h4 // see R06
        |=> rsp.cls == SDS_CL_CALL && !rsp.wide) else $error("16-bit call gate wrong");
    call32_a: assert property (req_valid && req.hi[11:8] == 4'hC // see R06
        |=> rsp.cls == SDS_CL_CALL && rsp.wide) else $error("32-bit call gate wrong");
    task_class_a: assert property (req_valid && req.hi[11:8] == 4'h5 // see R06
        |=> rsp.cls == SDS_CL_TASK) else $error("task gate class wrong");
    intr_class_a: assert property (req_valid && req.hi[11:8] == 4'h6 // see R06
        |=> rsp.cls == SDS_CL_INTR && !rsp.wide) else $error("16-bit interrupt gate wrong");
    intr32_a: assert property (req_valid && req.hi[11:8] == 4'hE // see R06
        |=> rsp.cls == SDS_CL_INTR && rsp.wide) else $error("32-bit interrupt gate wrong");
    trap16_a: assert property (req_valid && req.hi[11:8] == 4'h7 // see R06
        |=> rsp.cls == SDS_CL_TRAP && !rsp.wide) else $error("16-bit trap gate wrong");
    trap_class_a: assert property (req_valid && req.hi[11:8] == 4'hF // see R06
        |=> rsp.cls == SDS_CL_TRAP && rsp.wide) else $error("32-bit trap gate wrong");
    tss_avail_a: assert property (req_valid && req.hi[11:8] == 4'h9 // see R04
        |=> rsp.cls == SDS_CL_TSS && !rsp.busy && rsp.wide) else $error("available tss wrong");
    tss_old_busy_a: assert property (req_valid && req.hi[11:8] == 4'h3 // see R05
        |=> !rsp.wide && rsp.busy) else $error("busy 16-bit tss wrong");
    reserved_hi_a: assert property (req_valid && !req.hi[12] // see R19
        && (req.hi[11:8] == 4'hA || req.hi[11:8] == 4'hD)
        |=> rsp.gp && rsp.cls == SDS_CL_BAD) else $error("upper reserved type accepted");
    ldt_noptr_a: assert property (req_valid && req.hi[11:8] == 4'h2 // see R01
        |=> rsp.sel == 16'h0000 && rsp.offset == 32'h0000_0000)
        else $error("local table descriptor gave entry pointer");
    count_gate_a: assert property (req_valid && req.hi[10:8] != 3'h4 // see R07
        |=> rsp.copy_count == 5'h00) else $error("count used by non-call type");
    if_pass_a: assert property (req_valid && req.hi[11:8] == 4'hC // see R10
        |=> rsp.if_out == $past(req.if_in)) else $error("call gate changed if");

    // entry points, destination kinds, levels and the vectors they give;
    // the access bytes below are fully spelled so only one fault can apply
    intr_entry_a: assert property (req_valid && req.hi[11:8] == 4'hE // see R09
        |=> rsp.sel == $past(req.lo[31:16])
        && rsp.offset == {$past(req.hi[31:16]), $past(req.lo[15:0])})
        else $error("interrupt entry point wrong");
    gate_dest_a: assert property (req_valid && req.hi[15:8] == 8'hEC // see R12
        && !req.dest_access[3] |=> rsp.gp && rsp.vector == 8'h0D)
        else $error("call gate to non-code accepted");
    task_dest_a: assert property (req_valid && req.hi[15:8] == 8'hE5 // see R12
        && req.dest_access[4] |=> rsp.gp && rsp.vector == 8'h0D)
        else $error("task gate to non-tss accepted");
    task_ok_a: assert property (req_valid && req.hi[15:8] == 8'hE5 // see R11
        && req.dest_access == 8'h89 |=> !rsp.gp && !rsp.np)
        else $error("task gate to tss refused");
    level_ok_a: assert property (req_valid && req.hi[15:8] == 8'h8C // see R16
        && req.cpl == 2'h0 && req.dest_access == 8'h9A |=> !rsp.gp && !rsp.np)
        else $error("equal level refused");
    np_gate_a: assert property (req_valid && req.hi[15:8] == 8'h6C // see R13
        && req.dest_access == 8'h9A |=> rsp.np && rsp.vector == 8'h0B)
        else $error("absent call gate not flagged");
    gp_vector_a: assert property (rsp_valid && rsp.gp // see R12
        |-> rsp.vector == 8'h0D && !rsp.np) else $error("protection fault vector wrong");
    clean_vector_a: assert property (rsp_valid && !rsp.gp && !rsp.np // see R13
        |-> rsp.vector == 8'h00) else $error("vector without fault");

    // field extraction and the task selector; the selector only moves
    // on a write to its own offset
    base_hi_a: assert property (req_valid // see R18
        |=> fields.base[31:16] == {$past(req.hi[31:24]), $past(req.hi[7:0])}
        && fields.limit[15:0] == $past(req.lo[15:0])) else $error("upper base wrong");
    access_a: assert property (req_valid // see R15
        |=> fields.present == $past(req.hi[15]) && fields.descriptor_privilege_level == $past(req.hi[14:13])
        && fields.dtype == $past(req.hi[11:8])) else $error("access byte fields wrong");
    tsel_hold_a: assert property (!(reg_wr && reg_addr == 4'h0) // see R17
        |=> $stable(task_sel)) else $error("task selector changed without write");
    tsel_read_a: assert property (reg_rd && reg_addr == 4'h0 // see R17
        |=> reg_rdata == {16'h0000, $past(task_sel)})
        else $error("task selector read wrong");

    // scenarios worth seeing: an upper reserved code reaching the answer
    reserved_c: cover property (rsp_valid && rsp.gp && fields.dtype == 4'hD);

    call_ok_c: cover property (rsp_valid && rsp.cls == SDS_CL_CALL && !rsp.gp && !rsp.np
        && rsp.copy_count != 5'h00);
    task_np_c: cover property (rsp_valid && rsp.cls == SDS_CL_TASK && rsp.np);
    intr_gp_c: cover property (rsp_valid && rsp.cls == SDS_CL_INTR && rsp.gp);
    back2back_c: cover property (req_valid ##1 req_valid);

endmodule
`default_nettype wire

//--- bench/sds_core_model.sv
// partner model: core sequencing logic that issues descriptor requests
// assumes the checker answers on mclk one cycle after each request
`timescale 1ns/1ps
`default_nettype none
module sds_core_model
    import sds_pkg::*;
(
    input wire logic mclk,
    output logic req_valid,
    output sds_req_t req,
    input wire logic rsp_valid
);
    // quiet request port at time zero
    initial begin
        req_valid = 1'b0;
        req = '0;
    end
    // one-cycle strobe; released lines show the inverse so stale data never
    // passes for a request; the answer is awaited under a small bound
    task automatic issue(input sds_req_t r, output logic ok);
        @(posedge mclk);
        req_valid <= 1'b1;
        req <= r;
        @(posedge mclk);
        req_valid <= 1'b0;
        req <= ~r;
        ok = 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            #1 ok = (rsp_valid === 1'b1);
            if (!ok) @(posedge mclk);
        end
    endtask
endmodule
`default_nettype wire

//--- bench/sds_checker_tb_top.sv
// testbench of the system descriptor checker: one task per scenario
// assumes the core model drives requests and the bench owns the register port
`timescale 1ns/1ps
`default_nettype none
module sds_checker_tb_top;
    import sds_pkg::*;
    logic mclk, reset, req_valid, rsp_valid, reg_wr, reg_rd, ok;
    sds_req_t req;
    sds_rsp_t rsp;
    sds_fields_t fields;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rdv;
    logic [15:0] task_sel;
    int failures = 0;
    int total_checks = 0;
    sds_checker dut(.mclk(mclk), .reset(reset), .req_valid(req_valid), .req(req),
        .rsp_valid(rsp_valid), .rsp(rsp), .fields(fields), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .task_sel(task_sel));
    sds_core_model core(.mclk(mclk), .req_valid(req_valid), .req(req),
        .rsp_valid(rsp_valid));
    // 25 ns core clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // high word with only access byte set
    function automatic logic [31:0] hw(input logic [3:0] t, input logic p,
        input logic [1:0] d, input logic s);
        return {16'h0000, p, d, s, t, 8'h00};
    endfunction
    // one request through the core model; a hang ends the run
    task automatic send(input logic [31:0] lo, input logic [31:0] hi, input logic loc,
        input logic [1:0] cpl, input logic pc, input logic [7:0] da, input logic ifi);
        core.issue('{lo, hi, loc, cpl, pc, da, ifi}, ok);
        if (!ok) begin
            failures++;
            report_and_stop();
        end
    endtask
    task automatic t_types();
        logic [3:0] ty;
        sds_class_t ec;
        for (int t = 0; t < 16; t++) begin
            ty = 4'(t);
            send(32'h0, hw(ty, 1'b1, 2'h3, 1'b0), 1'b0, 2'h0, 1'b0,
                (ty == 4'h5) ? 8'h89 : 8'h9A, 1'b1);
            ec = SDS_CL_BAD;
            if (ty == 4'h2) ec = SDS_CL_LDT;
            if (ty inside {4'h1, 4'h3, 4'h9, 4'hB}) ec = SDS_CL_TSS;
            if (ty inside {4'h4, 4'hC}) ec = SDS_CL_CALL;
            if (ty == 4'h5) ec = SDS_CL_TASK;
            if (ty inside {4'h6, 4'hE}) ec = SDS_CL_INTR;
            if (ty inside {4'h7, 4'hF}) ec = SDS_CL_TRAP;
            chk(rsp.cls, ec);
            chk(rsp.gp, ec == SDS_CL_BAD);
            if (ec == SDS_CL_TSS) begin
                chk(rsp.busy, ty[1]);
                chk(rsp.wide, ty[3]);
            end
        end
        $display("type decode done");
    endtask
    task automatic t_faults();
        send(32'h0, hw(4'h2, 1'b1, 2'h3, 1'b0), 1'b1, 2'h0, 1'b0, 8'h00, 1'b0);
        chk(rsp.vector, SDS_VEC_GP);
        send(32'h0, hw(4'h2, 1'b1, 2'h0, 1'b0), 1'b0, 2'h3, 1'b0, 8'h00, 1'b0);
        chk(rsp.vector, SDS_VEC_NONE);
        send(32'h0, hw(4'hC, 1'b1, 2'h0, 1'b0), 1'b0, 2'h3, 1'b0, 8'h9A, 1'b0);
        chk(rsp.vector, SDS_VEC_GP);
        send(32'h0, hw(4'hC, 1'b0, 2'h3, 1'b0), 1'b0, 2'h0, 1'b0, 8'h9A, 1'b0);
        chk({rsp.np, rsp.vector}, {1'b1, SDS_VEC_NP});
        send(32'h0, hw(4'h5, 1'b0, 2'h3, 1'b0), 1'b0, 2'h0, 1'b0, 8'h89, 1'b0);
        chk({rsp.np, rsp.vector}, {1'b1, SDS_VEC_NP});
        send(32'h0, hw(4'hC, 1'b1, 2'h3, 1'b1), 1'b0, 2'h0, 1'b0, 8'h9A, 1'b0);
        chk(rsp.vector, SDS_VEC_GP);
        send(32'h0, hw(4'hE, 1'b1, 2'h3, 1'b0), 1'b0, 2'h0, 1'b0, 8'h92, 1'b0);
        chk(rsp.vector, SDS_VEC_GP);
        send(32'h0, hw(4'h5, 1'b1, 2'h3, 1'b0), 1'b0, 2'h0, 1'b0, 8'h9A, 1'b0);
        chk(rsp.vector, SDS_VEC_GP);
        $display("fault order done");
    endtask
    task automatic t_gates();
        send(32'h0028_1234, hw(4'hC, 1'b1, 2'h3, 1'b0) | 32'hABCD_0013, 1'b0, 2'h0,
            1'b1, 8'h9A, 1'b1);
        chk({rsp.sel, rsp.offset, rsp.copy_count}, {16'h0028, 32'hABCD_1234, 5'h13});
        send(32'h0028_1234, hw(4'hC, 1'b1, 2'h3, 1'b0) | 32'hABCD_0013, 1'b0, 2'h0,
            1'b0, 8'h9A, 1'b1);
        chk(rsp.copy_count, 5'h00);
        send(32'h0028_1234, hw(4'hE, 1'b1, 2'h3, 1'b0) | 32'hABCD_0013, 1'b0, 2'h0,
            1'b1, 8'h9A, 1'b1);
        chk({rsp.offset, rsp.copy_count, rsp.if_out}, {32'hABCD_1234, 5'h00, 1'b0});
        send(32'h0028_1234, hw(4'hF, 1'b1, 2'h3, 1'b0), 1'b0, 2'h0, 1'b0, 8'h9A, 1'b1);
        chk(rsp.if_out, 1'b1);
        send(32'h0028_1234, hw(4'h6, 1'b1, 2'h3, 1'b0) | 32'hABCD_0000, 1'b0, 2'h0,
            1'b0, 8'h9A, 1'b1);
        chk(rsp.offset, 32'h0000_1234);
        send(32'h0028_1234, hw(4'h5, 1'b1, 2'h3, 1'b0) | 32'hABCD_0000, 1'b0, 2'h0,
            1'b0, 8'h89, 1'b1);
        chk({rsp.sel, rsp.offset, rsp.gp}, {16'h0028, 32'h0, 1'b0});
        send(32'h5678_9ABC, 32'h128A_8934, 1'b0, 2'h0, 1'b0, 8'h00, 1'b0);
        chk({fields.base, fields.limit, fields.gran}, {32'h1234_5678, 20'hA9ABC, 1'b1});
        chk({fields.present, fields.descriptor_privilege_level, fields.dtype}, {1'b1, 2'h0, 4'h9});
        $display("gate fields done");
    endtask
    // register cycles: one strobe cycle, read data in the following cycle
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic t_regs();
        wr(SDS_REG_TASK_SEL, 32'hFFFF_1238);
        rd(SDS_REG_TASK_SEL, rdv);
        chk({task_sel, rdv}, {16'h1238, 32'h0000_1238});
        wr(4'h8, 32'hFFFF_FFFF);
        rd(4'h8, rdv);
        chk(rdv, 32'h0);
        send(32'h0, hw(4'h4, 1'b1, 2'h3, 1'b0), 1'b0, 2'h0, 1'b0, 8'h92, 1'b0);
        wr(SDS_REG_STATUS, 32'h0);
        rd(SDS_REG_STATUS, rdv);
        chk(rdv, 32'h0000_0D38);
        $display("registers done");
    endtask
    // reset, then every scenario in turn
    initial begin
        reset = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        #1 chk({task_sel, rsp_valid, reg_rdata}, {SDS_TASK_SEL_RST, 1'b0, 32'h0});
        t_types();
        t_faults();
        t_gates();
        t_regs();
        report_and_stop();
    end
endmodule
`default_nettype wire
